// ==== verilog/dtc_regs.vh ====
// Operation
// [RQ1] timer1 ticks every 4 or 12 clocks
// [RQ2] timer0 ticks every 4 or 12 clocks
// [RQ3] timer2 enable pulses every 4 or 12
// [RQ4] counter mode counts sampled pin falling edges
// [RQ5] timer1 counts only while its run set
// [RQ6] timer0 counts only while its run set
// [RQ7] timer1 flag cleared on interrupt entry, software
// [RQ8] timer0 flag cleared on interrupt entry, software
// [RQ9] timer1 gate bit adds pin gating
// [RQ10] timer0 gate bit adds pin gating
// [RQ11] timer1 source bit selects pin or clock
// [RQ12] timer0 source bit selects pin or clock
// [RQ13] mode 0: 5-bit prescaler, 13-bit count
// [RQ14] mode 1: bytes chained into 16 bits
// [RQ15] mode 2: 8-bit low byte, reload high
// [RQ16] mode 3: timer0 split, high uses timer1
// [RQ17] software uses mode 3 for timer0 only
// [RQ18] overflow sets flag, raises interrupt request
// [RQ19] timer1 in mode 3 holds its count
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// register indices; byte address is index times four
`define DTC_IDX_RUNFLAG 8'h88
`define DTC_IDX_MODESEL 8'h89
`define DTC_IDX_T0LOW 8'h8A
`define DTC_IDX_T1LOW 8'h8B
`define DTC_IDX_T0HIGH 8'h8C
`define DTC_IDX_T1HIGH 8'h8D
`define DTC_IDX_CLKDIV 8'h8E
`define DTC_IDX_LSB 2
`define DTC_IDX_MSB 9
`define DTC_ADDR_TOP 31

// reset values
`define DTC_RST_RUNFLAG 8'h00
`define DTC_RST_MODESEL 8'h00
`define DTC_RST_CLKDIV 8'hC7
// timeout select as held in the clkdiv reset value
`define DTC_RST_WDSEL 3'h7
`define DTC_RST_COUNT 8'h00

// run/flag control fields
`define DTC_RF_T1FLAG 7
`define DTC_RF_T1RUN 6
`define DTC_RF_T0FLAG 5
`define DTC_RF_T0RUN 4
`define DTC_RF_AUX_HI 3
`define DTC_RF_AUX_LO 0

// mode select fields
`define DTC_MS_T1GATE 7
`define DTC_MS_T1SRC 6
`define DTC_MS_T1MODE_HI 5
`define DTC_MS_T1MODE_LO 4
`define DTC_MS_T0GATE 3
`define DTC_MS_T0SRC 2
`define DTC_MS_T0MODE_HI 1
`define DTC_MS_T0MODE_LO 0

// clock divide fields
`define DTC_CK_WD1 7
`define DTC_CK_WD0 6
`define DTC_CK_T2DIV 5
`define DTC_CK_T1DIV 4
`define DTC_CK_T0DIV 3
`define DTC_CK_WD2 2

// counting modes
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// clock division factors
`define DTC_DIV_FAST 4
`define DTC_DIV_SLOW 12
`define DTC_DIV_W 4

`endif

// ==== verilog/dtc_prescale.v ====
`include "dtc_regs.vh"

module dtc_prescale #(
   parameter FAST = `DTC_DIV_FAST,
   parameter SLOW = `DTC_DIV_SLOW,
   parameter W = `DTC_DIV_W
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // divide select, 1 picks the fast factor
   input wire sel_fast,
   // one-cycle enable
   output wire tick
);

   localparam integer FAST_END = FAST - 1;
   localparam integer SLOW_END = SLOW - 1;
   localparam [W-1:0] LAST_FAST = FAST_END[W-1:0];
   localparam [W-1:0] LAST_SLOW = SLOW_END[W-1:0];

   reg [W-1:0] cnt_q;
   reg tick_q;
   wire [W-1:0] last;

   assign last = sel_fast ? LAST_FAST : LAST_SLOW;
   assign tick = tick_q;

   // >= catches a count left above the limit after a select change
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= {W{1'b0}};
         tick_q <= 1'b0;
      end
      else if (cnt_q >= last)
      begin
         cnt_q <= {W{1'b0}};
         tick_q <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
         tick_q <= 1'b0;
      end
   end

endmodule // dtc_prescale

// ==== verilog/dtc_top.v ====
`include "dtc_regs.vh"

module dtc_top (
   // clock and reset
   input wire CLK,
   input wire RST,
   // AHB-Lite slave
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output wire [31:0] HRDATA,
   output wire HREADYOUT,
   output wire HRESP,
   // external count and gate pins
   input wire T0_PIN,
   input wire T1_PIN,
   // cpu interrupt entry acknowledges
   input wire T0_ACK,
   input wire T1_ACK,
   // interrupt requests
   output wire T0_IRQ,
   output wire T1_IRQ,
   // timer 2 clock enable and watchdog timeout select
   output wire T2_TICK,
   output wire [2:0] WDT_SEL
);

   // bus state
   reg [31:0] rdata_q;
   reg ready_q;
   reg resp_q;
   reg wr_q;
   reg [7:0] widx_q;

   // software registers
   reg [7:0] runflag_q;
   reg [7:0] runflag_d;
   reg [7:0] modesel_q;
   reg [7:0] clkdiv_q;
   reg [7:0] tl0_q;
   reg [7:0] tl0_d;
   reg [7:0] th0_q;
   reg [7:0] th0_d;
   reg [7:0] tl1_q;
   reg [7:0] tl1_d;
   reg [7:0] th1_q;
   reg [7:0] th1_d;
   reg [2:0] wdsel_q;

   // pin synchronisers and filtered levels
   reg [1:0] pin_s1_q;
   reg [1:0] pin_s2_q;
   reg [1:0] pin_s3_q;
   reg [1:0] pin_f_q;

   // combinational working values
   reg ovf0;
   reg ovf1;
   reg ovf1_t1;
   reg [16:0] res0;
   reg [16:0] res1;

   wire access;
   wire addr_ok;
   wire [7:0] aidx;
   wire [7:0] wbyte;
   wire [1:0] pin_stable;
   wire [1:0] fall;
   wire [1:0] lvl;
   wire pre0;
   wire pre1;
   wire pre2;
   wire [1:0] t0_mode;
   wire [1:0] t1_mode;
   wire run0;
   wire run1;
   wire timer0_pin_gating_ok;
   wire timer1_pin_gating_ok;
   wire src0;
   wire src1;
   wire t0_inc;
   wire t1_inc;
   wire th0_inc;
   wire wr_rf;
   wire split0;

   // one counting step: returns {overflow, high, low}
   function [16:0] dtc_step;
      input [1:0] mode;
      input [7:0] tl;
      input [7:0] th;
      reg [8:0] lo;
      reg [5:0] lo5;
      reg [8:0] hi;
      begin
         lo = {1'b0, tl} + 9'h001;
         lo5 = {1'b0, tl[4:0]} + 6'h01;
         hi = {1'b0, th} + 9'h001;
         case (mode)
            `DTC_MODE_13BIT:
            begin
               if (lo5[5])
                  dtc_step = {hi[8], hi[7:0], tl[7:5], lo5[4:0]}; // [RQ13]
               else
                  dtc_step = {1'b0, th, tl[7:5], lo5[4:0]};
            end
            `DTC_MODE_16BIT:
            begin
               if (lo[8])
                  dtc_step = {hi[8], hi[7:0], lo[7:0]}; // [RQ14]
               else
                  dtc_step = {1'b0, th, lo[7:0]};
            end
            `DTC_MODE_RELOAD:
            begin
               if (lo[8])
                  dtc_step = {1'b1, th, th}; // [RQ15]
               else
                  dtc_step = {1'b0, th, lo[7:0]};
            end
            default:
            begin
               // low byte alone; high byte is stepped by the caller
               dtc_step = {lo[8], th, lo[7:0]}; // [RQ16]
            end
         endcase
      end
   endfunction

   // bus decode
   assign access = HSEL & HREADY & HTRANS[1];
   assign aidx = HADDR[`DTC_IDX_MSB:`DTC_IDX_LSB];
   assign addr_ok = (HADDR[`DTC_ADDR_TOP:`DTC_IDX_MSB+1] == 22'h000000) &
                    (HADDR[`DTC_IDX_LSB-1:0] == 2'h0);
   assign wbyte = HWDATA[7:0];
   assign wr_rf = wr_q & (widx_q == `DTC_IDX_RUNFLAG);

   // outputs
   assign HRDATA = rdata_q;
   assign HREADYOUT = ready_q;
   assign HRESP = resp_q;
   assign T0_IRQ = runflag_q[`DTC_RF_T0FLAG]; // [RQ18]
   assign T1_IRQ = runflag_q[`DTC_RF_T1FLAG]; // [RQ18]
   assign WDT_SEL = wdsel_q;

   // divided clock enables
   dtc_prescale u_pre0 (
      .clk(CLK),
      .rst(RST),
      .sel_fast(clkdiv_q[`DTC_CK_T0DIV]), // [RQ2]
      .tick(pre0)
   );

   dtc_prescale u_pre1 (
      .clk(CLK),
      .rst(RST),
      .sel_fast(clkdiv_q[`DTC_CK_T1DIV]), // [RQ1]
      .tick(pre1)
   );

   dtc_prescale u_pre2 (
      .clk(CLK),
      .rst(RST),
      .sel_fast(clkdiv_q[`DTC_CK_T2DIV]), // [RQ3]
      .tick(T2_TICK)
   );

   // pin edge detect on the filtered level
   assign pin_stable = ~(pin_s2_q ^ pin_s3_q);
   assign lvl = pin_f_q;
   assign fall = pin_f_q & pin_stable & ~pin_s3_q; // [RQ4]

   // count enables
   assign t0_mode = modesel_q[`DTC_MS_T0MODE_HI:`DTC_MS_T0MODE_LO];
   assign t1_mode = modesel_q[`DTC_MS_T1MODE_HI:`DTC_MS_T1MODE_LO];
   assign split0 = (t0_mode == `DTC_MODE_SPLIT);
   assign run0 = runflag_q[`DTC_RF_T0RUN];
   assign run1 = runflag_q[`DTC_RF_T1RUN];
   assign timer0_pin_gating_ok = ~modesel_q[`DTC_MS_T0GATE] | lvl[0]; // [RQ10]
   assign timer1_pin_gating_ok = ~modesel_q[`DTC_MS_T1GATE] | lvl[1]; // [RQ9]
   assign src0 = modesel_q[`DTC_MS_T0SRC] ? fall[0] : pre0; // [RQ12]
   assign src1 = modesel_q[`DTC_MS_T1SRC] ? fall[1] : pre1; // [RQ11]
   assign t0_inc = run0 & timer0_pin_gating_ok & src0; // [RQ6]
   assign t1_inc = run1 & timer1_pin_gating_ok & src1 & ~split0; // [RQ5]
   // split high byte: timer 0 clock, timer 1 run and gate
   assign th0_inc = split0 & run1 & timer1_pin_gating_ok & pre0; // [RQ16]

   // next counter values
   always @*
   begin
      res0 = dtc_step(t0_mode, tl0_q, th0_q);
      res1 = dtc_step(t1_mode, tl1_q, th1_q);
      tl0_d = tl0_q;
      th0_d = th0_q;
      tl1_d = tl1_q;
      th1_d = th1_q;
      ovf0 = 1'b0;
      ovf1 = 1'b0;
      ovf1_t1 = 1'b0;
      if (t0_inc)
      begin
         ovf0 = res0[16];
         th0_d = res0[15:8];
         tl0_d = res0[7:0];
      end
      if (th0_inc)
      begin
         th0_d = th0_q + 8'h01;
         ovf1 = (th0_q == 8'hFF); // [RQ16]
      end
      // mode 3 on timer 1 holds the count
      if (t1_inc && (t1_mode != `DTC_MODE_SPLIT)) // [RQ19]
      begin
         ovf1_t1 = res1[16];
         th1_d = res1[15:8];
         tl1_d = res1[7:0];
      end
      // timer 1 flag belongs to the split high byte in mode 3
      if (!split0)
         ovf1 = ovf1_t1;
      // software write replaces the count step
      if (wr_q)
      begin
         case (widx_q)
            `DTC_IDX_T0LOW: tl0_d = wbyte;
            `DTC_IDX_T0HIGH: th0_d = wbyte;
            `DTC_IDX_T1LOW: tl1_d = wbyte;
            `DTC_IDX_T1HIGH: th1_d = wbyte;
            default: tl0_d = tl0_d;
         endcase
      end
   end

   // run/flag register next value; an overflow set always wins over a clear
   always @*
   begin
      runflag_d = runflag_q;
      if (wr_rf)
         runflag_d = wbyte;
      if (T0_ACK)
         runflag_d[`DTC_RF_T0FLAG] = 1'b0; // [RQ8]
      if (T1_ACK)
         runflag_d[`DTC_RF_T1FLAG] = 1'b0; // [RQ7]
      if (ovf0)
         runflag_d[`DTC_RF_T0FLAG] = 1'b1; // [RQ18]
      if (ovf1)
         runflag_d[`DTC_RF_T1FLAG] = 1'b1; // [RQ18]
   end

   // pin synchronisers
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
         pin_s3_q <= 2'h0;
         pin_f_q <= 2'h0;
      end
      else
      begin
         pin_s1_q <= {T1_PIN, T0_PIN};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_f_q <= (pin_f_q & ~pin_stable) | (pin_s3_q & pin_stable);
      end
   end

   // bus slave: zero wait, read data registered in the address phase
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         rdata_q <= 32'h00000000;
         ready_q <= 1'b1;
         resp_q <= 1'b0;
         wr_q <= 1'b0;
         widx_q <= 8'h00;
      end
      else
      begin
         wr_q <= access & HWRITE & addr_ok;
         widx_q <= aidx;
         if (access && !HWRITE)
         begin
            rdata_q <= 32'h00000000;
            if (addr_ok)
            begin
               case (aidx)
                  `DTC_IDX_RUNFLAG: rdata_q[7:0] <= runflag_q;
                  `DTC_IDX_MODESEL: rdata_q[7:0] <= modesel_q;
                  `DTC_IDX_T0LOW: rdata_q[7:0] <= tl0_q;
                  `DTC_IDX_T1LOW: rdata_q[7:0] <= tl1_q;
                  `DTC_IDX_T0HIGH: rdata_q[7:0] <= th0_q;
                  `DTC_IDX_T1HIGH: rdata_q[7:0] <= th1_q;
                  `DTC_IDX_CLKDIV: rdata_q[7:0] <= clkdiv_q;
                  default: rdata_q[7:0] <= 8'h00;
               endcase
            end
         end
      end
   end

   // configuration registers
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         modesel_q <= `DTC_RST_MODESEL;
         clkdiv_q <= `DTC_RST_CLKDIV;
         wdsel_q <= `DTC_RST_WDSEL;
      end
      else
      begin
         if (wr_q && (widx_q == `DTC_IDX_MODESEL))
            modesel_q <= wbyte;
         if (wr_q && (widx_q == `DTC_IDX_CLKDIV))
            clkdiv_q <= wbyte;
         wdsel_q <= {clkdiv_q[`DTC_CK_WD2], clkdiv_q[`DTC_CK_WD1],
                     clkdiv_q[`DTC_CK_WD0]};
      end
   end

   // counters and run/flag register
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         runflag_q <= `DTC_RST_RUNFLAG;
         tl0_q <= `DTC_RST_COUNT;
         th0_q <= `DTC_RST_COUNT;
         tl1_q <= `DTC_RST_COUNT;
         th1_q <= `DTC_RST_COUNT;
      end
      else
      begin
         runflag_q <= runflag_d;
         tl0_q <= tl0_d;
         th0_q <= th0_d;
         tl1_q <= tl1_d;
         th1_q <= th1_d;
      end
   end

endmodule // dtc_top

// ==== tb/dtc_top_sva.sv ====
module dtc_chk (
   // clock and reset
   input wire CLK,
   input wire RST,
   // bus
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   input wire [31:0] HRDATA,
   input wire HREADYOUT,
   input wire HRESP,
   // timer side
   input wire T0_ACK,
   input wire T1_ACK,
   input wire T0_IRQ,
   input wire T1_IRQ,
   input wire T2_TICK
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   logic wp_q, wr_q, wr2_q, cl_q, t2f_q;
   logic [3:0] cnt_q;
   wire tk = HSEL && HREADY && HTRANS[1];
   // cl_q: no divider write since the last tick
   always @(posedge CLK or posedge RST)
      if (RST)
      begin
         {wp_q, wr_q, wr2_q, cl_q, t2f_q} <= 5'h0;
         cnt_q <= 4'h0;
      end
      else
      begin
         wp_q <= tk && HWRITE && HADDR == 32'h238;
         wr_q <= tk && HWRITE;
         wr2_q <= wr_q;
         cnt_q <= T2_TICK ? 4'h0 : cnt_q + 4'h1;
         cl_q <= T2_TICK ? !wp_q : cl_q && !wp_q;
         if (wp_q)
            t2f_q <= HWDATA[5];
      end
   property p_rdy; HREADYOUT == 1'h1; endproperty
   a_rdy: assert property (p_rdy) else $error("wait state");
   property p_okay; HRESP == 1'h0; endproperty
   a_okay: assert property (p_okay) else $error("bad response");
   property p_hi; HRDATA[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_unm; tk && !HWRITE && (HADDR < 32'h220 || HADDR > 32'h238)
      |=> HRDATA == 32'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_t2p; T2_TICK && cl_q |-> cnt_q == (t2f_q ? 4'h3 : 4'hB);
   endproperty
   a_t2p: assert property (p_t2p) else $error("t2 period");
   property p_t2g; T2_TICK |=> !T2_TICK; endproperty
   a_t2g: assert property (p_t2g) else $error("t2 double");
   property p_rst; $fell(RST) |-> !T0_IRQ && !T1_IRQ; endproperty
   a_rst: assert property (p_rst) else $error("irq after reset");
   property p_ack0; T0_ACK && T0_IRQ |-> ##[1:2] !T0_IRQ; endproperty
   a_ack0: assert property (p_ack0) else $error("t0 ack");
   property p_ack1; T1_ACK && T1_IRQ |-> ##[1:2] !T1_IRQ; endproperty
   a_ack1: assert property (p_ack1) else $error("t1 ack");
   property p_hold; T0_IRQ && !T0_ACK && !$past(T0_ACK) && !wr_q && !wr2_q
      |=> T0_IRQ; endproperty
   a_hold: assert property (p_hold) else $error("t0 flag lost");
   c_t2: cover property (T2_TICK && cl_q && t2f_q);
   c_ack0: cover property (T0_ACK && T0_IRQ);
   c_ack1: cover property (T1_ACK && T1_IRQ);
endmodule // dtc_chk
bind dtc_top dtc_chk dtc_chk_inst (.CLK(CLK), .RST(RST), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
   .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .T0_ACK(T0_ACK), .T1_ACK(T1_ACK), .T0_IRQ(T0_IRQ),
   .T1_IRQ(T1_IRQ), .T2_TICK(T2_TICK));

// ==== tb/dtc_far.sv ====
module dtc_far (
   // clock and reset
   input wire CLK,
   input wire RST,
   // cpu side
   input wire T0_IRQ,
   input wire T1_IRQ,
   output logic T0_ACK,
   output logic T1_ACK,
   // pins
   output logic T0_PIN,
   output logic T1_PIN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] w0_q, w1_q;
   initial {T0_PIN, T1_PIN} = 2'h3;
   // routine entered a few cycles after the request
   always @(posedge CLK or posedge RST)
      if (RST)
         {w0_q, w1_q, T0_ACK, T1_ACK} <= 6'h0;
      else
      begin
         w0_q <= T0_IRQ && !T0_ACK ? w0_q + 2'h1 : 2'h0;
         w1_q <= T1_IRQ && !T1_ACK ? w1_q + 2'h1 : 2'h0;
         T0_ACK <= w0_q == 2'h2;
         T1_ACK <= w1_q == 2'h2;
      end
   task automatic edges(input int n);
      repeat (n)
      begin
         @(posedge CLK);
         {T0_PIN, T1_PIN} <= 2'h0;
         repeat (3) @(posedge CLK);
         {T0_PIN, T1_PIN} <= 2'h3;
         repeat (3) @(posedge CLK);
      end
   endtask
   task automatic level(input logic v);
      @(posedge CLK);
      {T0_PIN, T1_PIN} <= {v, v};
   endtask
endmodule // dtc_far

// ==== tb/dtc_top_test.sv ====
`include "dtc_regs.vh"
module dtc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 1'h0, RST = 1'h1, HSEL = 1'h0, HWRITE = 1'h0, dp = 1'h0;
   logic [1:0] HTRANS = 2'h0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, r, e;
   logic [31:0] q[$];
   // {mode, low byte, run/flag, pin, high byte after}
   logic [31:0] tv[5] = '{32'h001E1011, 32'h011E1010, 32'h01FF4010,
      32'h09FF1000, 32'h09FF1011};
   wire [31:0] HRDATA;
   wire [2:0] WDT_SEL;
   wire HREADYOUT, HRESP, T0_IRQ, T1_IRQ, T2_TICK;
   wire T0_PIN, T1_PIN, T0_ACK, T1_ACK;
   int n_errors = 0, tests_run = 0;
   dtc_top dtc_top_inst (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .T0_PIN(T0_PIN), .T1_PIN(T1_PIN), .T0_ACK(T0_ACK),
      .T1_ACK(T1_ACK), .T0_IRQ(T0_IRQ), .T1_IRQ(T1_IRQ),
      .T2_TICK(T2_TICK), .WDT_SEL(WDT_SEL));
   dtc_far dtc_far_inst (.CLK(CLK), .RST(RST), .T0_IRQ(T0_IRQ),
      .T1_IRQ(T1_IRQ), .T0_ACK(T0_ACK), .T1_ACK(T1_ACK), .T0_PIN(T0_PIN),
      .T1_PIN(T1_PIN));
   initial forever #2.5 CLK = ~CLK;
   task automatic chk(input string nm, input logic [31:0] s, x);
      tests_run++;
      if (s !== x)
      begin
         n_errors++;
         $display("Error %s exp %h seen %h", nm, x, s);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
      HSEL <= 1'h1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= {22'h0, i, 2'h0};
      do @(posedge CLK); while (HREADYOUT !== 1'h1);
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'h1);
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      bus(1'h1, i, d);
   endtask
   task automatic rd(input logic [7:0] i, input logic [31:0] x);
      q.push_back(x);
      bus(1'h0, i, 32'h0);
   endtask
   // read data checked at the data phase edge
   always @(posedge CLK)
   begin
      if (dp)
      begin
         e = q.pop_front();
         chk("HRDATA", HRDATA, e);
      end
      dp <= HSEL && HREADYOUT && HTRANS[1] && !HWRITE;
   end
   function automatic logic sig(input int b);
      return b == 0 ? T0_IRQ : b == 1 ? T1_IRQ : T2_TICK;
   endfunction
   // cycles between two rises
   task automatic gap(input int b, input int x);
      int n;
      n = 0;
      do @(posedge CLK); while (sig(b) === 1'h1);
      do @(posedge CLK); while (sig(b) !== 1'h1);
      do
      begin
         @(posedge CLK);
         n++;
      end while (sig(b) === 1'h1);
      do
      begin
         @(posedge CLK);
         n++;
      end while (sig(b) !== 1'h1);
      chk("period", 32'(n), 32'(x));
   endtask
   initial
   begin
      void'($urandom(61442));
      r = $urandom;
      repeat (20) @(posedge CLK);
      RST <= 1'h0;
      @(posedge CLK);
      rd(`DTC_IDX_RUNFLAG, 32'h0);
      rd(`DTC_IDX_MODESEL, 32'h0);
      rd(`DTC_IDX_CLKDIV, 32'hC7);
      chk("WDT_SEL", WDT_SEL, 32'h7);
      wr(8'h80, r);
      rd(8'h80, 32'h0);
      wr(`DTC_IDX_T1HIGH, r);
      rd(`DTC_IDX_T1HIGH, {24'h0, r[7:0]});
      gap(2, 12);
      wr(`DTC_IDX_CLKDIV, 32'hE7);
      gap(2, 4);
      wr(`DTC_IDX_MODESEL, 32'h22);
      wr(`DTC_IDX_T0HIGH, 32'hF0);
      wr(`DTC_IDX_T1HIGH, 32'hF0);
      wr(`DTC_IDX_RUNFLAG, 32'h50);
      gap(0, 192);
      gap(1, 192);
      wr(`DTC_IDX_CLKDIV, 32'hFF);
      gap(0, 64);
      gap(1, 64);
      foreach (tv[i])
      begin
         dtc_far_inst.level(tv[i][4]);
         wr(`DTC_IDX_RUNFLAG, 32'h0);
         wr(`DTC_IDX_MODESEL, tv[i][31:24]);
         wr(`DTC_IDX_T0LOW, tv[i][23:16]);
         wr(`DTC_IDX_T0HIGH, 32'h0);
         wr(`DTC_IDX_RUNFLAG, tv[i][15:8]);
         repeat (120) @(posedge CLK);
         wr(`DTC_IDX_RUNFLAG, 32'h0);
         rd(`DTC_IDX_T0HIGH, tv[i][0]);
      end
      wr(`DTC_IDX_MODESEL, 32'h55);
      wr(`DTC_IDX_T0LOW, 32'h0);
      wr(`DTC_IDX_T1LOW, 32'h0);
      wr(`DTC_IDX_RUNFLAG, 32'h50);
      dtc_far_inst.edges(5);
      repeat (8) @(posedge CLK);
      rd(`DTC_IDX_T0LOW, 32'h5);
      rd(`DTC_IDX_T1LOW, 32'h5);
      wr(`DTC_IDX_RUNFLAG, 32'h0);
      // timer 1 gated by its pin
      dtc_far_inst.level(1'h0);
      wr(`DTC_IDX_MODESEL, 32'h90);
      wr(`DTC_IDX_T1LOW, 32'hFF);
      wr(`DTC_IDX_T1HIGH, 32'h0);
      wr(`DTC_IDX_RUNFLAG, 32'h40);
      repeat (40) @(posedge CLK);
      rd(`DTC_IDX_T1HIGH, 32'h0);
      dtc_far_inst.level(1'h1);
      repeat (40) @(posedge CLK);
      rd(`DTC_IDX_T1HIGH, 32'h1);
      wr(`DTC_IDX_RUNFLAG, 32'h0);
      wr(`DTC_IDX_MODESEL, 32'h03);
      wr(`DTC_IDX_T0LOW, 32'h0);
      wr(`DTC_IDX_T1LOW, r);
      wr(`DTC_IDX_RUNFLAG, 32'h40);
      gap(1, 1024);
      rd(`DTC_IDX_T0LOW, 32'h0);
      rd(`DTC_IDX_T1LOW, {24'h0, r[7:0]});
      wr(`DTC_IDX_MODESEL, 32'h30);
      repeat (80) @(posedge CLK);
      rd(`DTC_IDX_T1LOW, {24'h0, r[7:0]});
      // timeout select follows clkdiv bits 2, 7, 6
      wr(`DTC_IDX_CLKDIV, 32'h43);
      repeat (2) @(posedge CLK);
      chk("WDT_SEL", WDT_SEL, 32'h1);
      rd(`DTC_IDX_CLKDIV, 32'h43);
      finish_test();
   end
   initial
   begin
      #100us;
      n_errors++;
      finish_test();
   end
endmodule // dtc_top_test
